// ==== dpwc_pkg.sv ====
// Purpose: shared constants and carrier types for the half-rate write and
//          address/command path
// Assumes: n = 8 dq bits, one write byte mask bit per beat, 13-bit address
// Notes:   all timing counts derive from the 200 MHz system clock
`default_nettype none

package dpwc_pkg;

    // bus widths
    localparam int DQ_W   = 8;            // n, memory data width
    localparam int WORD_W = 4 * DQ_W;     // 4n controller word
    localparam int SDR_W  = 2 * DQ_W;     // 2n single-data-rate half
    localparam int MASK_W = 4;            // one mask bit per beat
    localparam int ADDR_W = 13;
    localparam int BANK_W = 2;

    // buffering
    localparam int FIFO_DEPTH = 16;
    localparam int LEVEL_W    = 5;
    // headroom for words still in flight through the input synchroniser
    localparam logic [LEVEL_W-1:0] READY_LIMIT = 5'h0D;

    // timing: memory clock half period in ns and its cycle count
    localparam int SYS_CLK_PERIOD_NS  = 5;
    localparam int MEM_HALF_PERIOD_NS = 15;
    localparam int TICK_CYC_INT =
        (MEM_HALF_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam logic [1:0] TICK_LAST = 2'(TICK_CYC_INT - 1);

    // beats within one command slot (two memory clock cycles)
    localparam logic [1:0] SLOT_LAST = 2'h3;
    localparam logic [1:0] SLOT_CS2T = 2'h2;

    // address/command clock phase, build-time choice
    typedef enum {
        DPWC_PH_0,
        DPWC_PH_90,
        DPWC_PH_180,
        DPWC_PH_270
    } dpwc_phase_t;

    // one controller request: command, address and its write word
    typedef struct packed {
        logic                write;   // word carries write data
        logic                ras_n;
        logic                cas_n;
        logic                we_n;
        logic                cs;      // 1: select the device
        logic                cke;
        logic                odt;
        logic [BANK_W-1:0]   bank;
        logic [ADDR_W-1:0]   addr;
        logic [WORD_W-1:0]   wdata;
        logic [MASK_W-1:0]   wmask;
    } dpwc_cmd_t;

    // what the block drives towards the memory
    typedef struct packed {
        logic                memory_clock_out;
        logic [ADDR_W-1:0]   addr;
        logic [BANK_W-1:0]   bank;
        logic                ras_n;
        logic                cas_n;
        logic                we_n;
        logic                cs_n;
        logic                cke;
        logic                odt;
        logic [DQ_W-1:0]     dq_out;
        logic                dq_oe;
        logic                dqs_out;
        logic                dqs_oe;
        logic                write_byte_mask;
    } dpwc_mem_out_t;

    // slot contents after a pop
    typedef struct packed {
        logic                live;
        dpwc_cmd_t           cmd;
    } dpwc_slot_t;

    // whole state of the top module
    typedef struct packed {
        logic [1:0]          rst_pipe;
        logic                ctl_prev;
        logic                ctl_ready;
        logic                dual;
        logic [1:0]          tick_cnt;
        logic [1:0]          hc;
        dpwc_slot_t          cur;
        dpwc_slot_t          ac;
        dpwc_mem_out_t       mo;
    } dpwc_state_t;

    localparam dpwc_mem_out_t MO_RST = '{
        memory_clock_out: 1'b0, addr: '0, bank: '0, ras_n: 1'b1,
        cas_n: 1'b1, we_n: 1'b1, cs_n: 1'b1, cke: 1'b0, odt: 1'b0,
        dq_out: '0, dq_oe: 1'b0, dqs_out: 1'b0, dqs_oe: 1'b0,
        write_byte_mask: 1'b0};

    localparam dpwc_state_t STATE_RST = '{
        rst_pipe: 2'h0, ctl_prev: 1'b0, ctl_ready: 1'b0, dual: 1'b0,
        tick_cnt: 2'h0, hc: SLOT_LAST, cur: '0, ac: '0, mo: MO_RST};

    // half-cycle within the slot at which commands launch
    function automatic logic [1:0] dpwc_launch_hc(input dpwc_phase_t ph);
        dpwc_launch_hc = (ph == DPWC_PH_90) ? 2'h1 : 2'h0;
    endfunction : dpwc_launch_hc

endpackage : dpwc_pkg

`default_nettype wire

// ==== dpwc_sync.sv ====
// Purpose: two-flop synchroniser for a group of levels
// Assumes: every bit is quasi-static around the sampling point
// Notes:   the first stage is read by the second stage only
`default_nettype none

module dpwc_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,   // system clock
    input  wire logic         rst_n,     // synchronous reset, active low
    input  wire logic [W-1:0] d_in,      // asynchronous levels
    output logic      [W-1:0] d_out      // synchronised levels
);

    logic [W-1:0] meta_reg;

    // plain two-stage shift; no logic may look at meta_reg
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            d_out    <= '0;
        end else begin
            meta_reg <= d_in;
            d_out    <= meta_reg;
        end
    end

endmodule : dpwc_sync

`default_nettype wire

// ==== dpwc_fifo.sv ====
// Purpose: word buffer between the half-rate intake and the memory slots
// Assumes: push only when in_ready, pop only when out_valid
// Notes:   level lets the producer throttle early
`default_nettype none

module dpwc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16,
    parameter int LW    = 5
) (
    input  wire logic          sys_clk,    // system clock
    input  wire logic          rst_n,      // synchronous reset, active low
    input  wire logic          in_valid,   // push request
    output logic               in_ready,   // not full
    input  wire logic [W-1:0]  in_data,    // pushed word
    output logic               out_valid,  // not empty
    input  wire logic          out_ready,  // pop request
    output logic      [W-1:0]  out_data,   // head word
    output logic      [LW-1:0] level       // words held
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic          push;
    logic          pop;

    // flags from the level so full and empty are exact
    assign in_ready  = (level != LW'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_ready & out_valid;

    // storage has no reset, pointers do
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            level  <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + AW'(1);
            end
            if (pop) begin
                rd_reg <= rd_reg + AW'(1);
            end
            level <= level + LW'(push) - LW'(pop);
        end
    end

endmodule : dpwc_fifo

`default_nettype wire

// ==== dpwc_top.sv ====
// Purpose: half-rate write datapath and address/command path towards a
//          double-data-rate memory
// Assumes: controller signals and its half-rate clock arrive unsynchronised;
//          the memory clock is derived here from sys_clk
// Notes:   one command slot is four memory half-cycles; phase is a parameter
`default_nettype none

// What this block does
// - take a 4n word per half-rate cycle
// - split word into rising and falling halves
// - drive n bits on both memory edges
// - beat order reverses the read alignment
// - reissue half-rate commands on memory clock
// - single-cycle timing holds command one cycle
// - dual-cycle timing holds command two cycles
// - burst four, local burst size one
// - at most one command per two cycles
// - chip select active low masks commands
// - command group is ras cas we cs cke odt
// - launch on phase edge, stay two cycles
// - dual-cycle chip select low one cycle after launch
// - chip select only in alternate cycles
// - address advances every second cycle
// - address/command phase is a build setting
// - 180 and 270 launch on rising edge
// - dq, dqs, their enables and mask logic
// - resets release through two registers
module dpwc_top
    import dpwc_pkg::*;
#(
    parameter dpwc_phase_t AC_PHASE = DPWC_PH_0   // address/command phase
) (
    input  wire logic       sys_clk,            // 200 MHz system clock
    input  wire logic       rst_n,              // synchronous reset, low
    input  wire logic       half_rate_sys_clk,  // controller half-rate clk
    input  wire logic       ctl_valid,          // controller word valid
    input  wire dpwc_cmd_t  ctl_cmd,            // controller command, word
    input  wire logic       dual_cycle_cmd_timing, // 1: two-cycle commands
    output logic            ctl_ready,          // room for another word
    output dpwc_mem_out_t   mem_out             // memory-facing signals
);

    localparam int SYNC_W = $bits(dpwc_cmd_t) + 3;
    localparam logic [1:0] LAUNCH_HC = dpwc_launch_hc(AC_PHASE);

    dpwc_state_t s_reg;
    dpwc_state_t s_next;

    logic [SYNC_W-1:0] sync_q;
    logic              clk_s;
    logic              valid_s;
    logic              dual_s;
    dpwc_cmd_t         cmd_s;

    logic              fifo_in_ready;
    logic              fifo_out_valid;
    dpwc_cmd_t         fifo_out_data;
    logic [LEVEL_W-1:0] fifo_level;
    logic              push;
    logic              pop;
    logic              tick;
    logic [1:0]        h_new;

    // every controller signal shares one synchroniser so the word lines
    // up with the sampled half-rate clock edge
    dpwc_sync #(
        .W (SYNC_W)
    ) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .d_in    ({half_rate_sys_clk, ctl_valid, dual_cycle_cmd_timing,
                   ctl_cmd}),
        .d_out   (sync_q)
    );

    assign clk_s   = sync_q[SYNC_W-1];
    assign valid_s = sync_q[SYNC_W-2];
    assign dual_s  = sync_q[SYNC_W-3];
    assign cmd_s   = sync_q[SYNC_W-4:0];

    // one push per rising half-rate edge; the word is stable all cycle
    assign push = clk_s & ~s_reg.ctl_prev & valid_s
                  & s_reg.rst_pipe[1];

    // memory half-cycle tick and the slot position after it
    assign tick  = (s_reg.tick_cnt == TICK_LAST);
    assign h_new = s_reg.hc + 2'h1;

    // pop only at the slot boundary, so one command per slot
    assign pop = tick & (s_reg.hc == SLOT_LAST) & fifo_out_valid;

    dpwc_fifo #(
        .W     ($bits(dpwc_cmd_t)),
        .DEPTH (FIFO_DEPTH),
        .LW    (LEVEL_W)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (cmd_s),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // beat k of the slot is word bits [k*n +: n]; even beats ride the
    // rising edge, odd beats the falling edge
    function automatic logic [DQ_W-1:0] beat_of(
        input logic [WORD_W-1:0] w,
        input logic [1:0]        h
    );
        logic [SDR_W-1:0] sdr_h;
        logic [SDR_W-1:0] sdr_l;
        sdr_h = {w[2*DQ_W +: DQ_W], w[0 +: DQ_W]};
        sdr_l = {w[3*DQ_W +: DQ_W], w[DQ_W +: DQ_W]};
        if (h[0]) begin
            beat_of = sdr_l[h[1]*DQ_W +: DQ_W];
        end else begin
            beat_of = sdr_h[h[1]*DQ_W +: DQ_W];
        end
    endfunction : beat_of

    // next state of the whole block
    always_comb begin
        dpwc_slot_t slot_src;
        logic [1:0] rel;
        slot_src = '0;
        rel      = 2'h0;
        s_next   = s_reg;

        // reset release walks through two registers
        s_next.rst_pipe = {s_reg.rst_pipe[0], 1'b1};
        s_next.ctl_prev = clk_s;
        // registered ready with headroom for words in flight
        s_next.ctl_ready = fifo_in_ready
                           & (fifo_level <= READY_LIMIT);
        // mode follows the strap only at slot edges, never mid-command
        if (tick && s_reg.hc == SLOT_LAST) begin
            s_next.dual = dual_s;
        end

        if (tick) begin
            s_next.tick_cnt = 2'h0;
            s_next.hc       = h_new;
            // memory clock runs at half-cycle ticks: high on even beats
            s_next.mo.memory_clock_out = ~h_new[0];

            // load a new slot at the boundary, or an idle slot
            if (h_new == 2'h0) begin
                s_next.cur.live = pop;
                s_next.cur.cmd  = pop ? fifo_out_data : s_reg.cur.cmd;
            end
            slot_src = (h_new == 2'h0) ? s_next.cur : s_reg.cur;

            // position relative to the launch edge of the phase setting
            rel = h_new - LAUNCH_HC;

            if (rel == 2'h0) begin
                // launch: whole group changes together, except select in dual-cycle timing
                s_next.ac = slot_src;
                s_next.mo.addr = slot_src.cmd.addr;
                s_next.mo.bank = slot_src.cmd.bank;
                if (slot_src.live) begin
                    s_next.mo.ras_n = slot_src.cmd.ras_n;
                    s_next.mo.cas_n = slot_src.cmd.cas_n;
                    s_next.mo.we_n  = slot_src.cmd.we_n;
                    s_next.mo.cke   = slot_src.cmd.cke;
                    s_next.mo.odt   = slot_src.cmd.odt;
                end else begin
                    // idle slot: no-operation code, cke and odt keep their last values
                    s_next.mo.ras_n = 1'b1;
                    s_next.mo.cas_n = 1'b1;
                    s_next.mo.we_n  = 1'b1;
                end
                if (s_next.dual) begin
                    // hold select off while the code settles
                    s_next.mo.cs_n = 1'b1;
                end else begin
                    s_next.mo.cs_n = ~(slot_src.live
                                       & slot_src.cmd.cs);
                end
            end else if (rel == SLOT_CS2T) begin
                if (s_reg.dual) begin
                    // code has stood one full cycle; select now
                    s_next.mo.cs_n = ~(s_reg.ac.live
                                       & s_reg.ac.cmd.cs);
                end else begin
                    // single-cycle: code is gone after one cycle
                    s_next.mo.cs_n  = 1'b1;
                    s_next.mo.ras_n = 1'b1;
                    s_next.mo.cas_n = 1'b1;
                    s_next.mo.we_n  = 1'b1;
                end
            end else if (rel == 2'h1) begin
                // chip select never spans two slots of a back-to-back run
                s_next.mo.cs_n = s_reg.mo.cs_n | s_reg.dual;
            end else begin
                // last quarter: dual-cycle select ends here, a half-cycle before the command
                if (s_reg.dual) begin
                    s_next.mo.cs_n = 1'b1;
                end
            end

            // write datapath: dq, strobe, enables and mask per beat
            if (slot_src.live && slot_src.cmd.write) begin
                s_next.mo.dq_out  = beat_of(slot_src.cmd.wdata,
                                            h_new);
                s_next.mo.write_byte_mask =
                    slot_src.cmd.wmask[h_new];
                s_next.mo.dq_oe   = 1'b1;
                s_next.mo.dqs_oe  = 1'b1;
                s_next.mo.dqs_out = ~h_new[0];
            end else begin
                s_next.mo.dq_oe   = 1'b0;
                s_next.mo.dqs_oe  = 1'b0;
                s_next.mo.dqs_out = 1'b0;
                s_next.mo.write_byte_mask = 1'b0;
            end
        end else begin
            s_next.tick_cnt = s_reg.tick_cnt + 2'h1;
        end

        // internal reset holds until the release has passed two stages
        if (!s_reg.rst_pipe[1]) begin
            s_next          = STATE_RST;
            s_next.rst_pipe = {s_reg.rst_pipe[0], 1'b1};
        end
    end

    // single state register; reset acts at once, release is delayed
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign ctl_ready = s_reg.ctl_ready;
    assign mem_out   = s_reg.mo;

endmodule : dpwc_top

`default_nettype wire

// ==== dpwc_top_sva.sv ====
// Purpose: assertions on the pins of dpwc_top
// Assumes: one memory half-cycle (tick) is three sys_clk cycles
// Notes:   the launch-edge check covers single-cycle timing only
`default_nettype none

module dpwc_top_sva
    import dpwc_pkg::*;
#(
    parameter dpwc_phase_t AC_PHASE = DPWC_PH_0  // address/command phase
) (
    input wire logic          sys_clk,               // system clock
    input wire logic          rst_n,                 // reset, active low
    input wire logic          half_rate_sys_clk,     // controller clock
    input wire logic          ctl_valid,             // word valid
    input wire dpwc_cmd_t     ctl_cmd,               // command and word
    input wire logic          dual_cycle_cmd_timing, // two-cycle mode
    input wire logic          ctl_ready,             // room for a word
    input wire dpwc_mem_out_t mem_out                // memory pins
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic LAUNCH_HI = (AC_PHASE != DPWC_PH_90);
    logic       mclk_q;  // memory clock at the last sample
    logic       tick;    // memory clock moved since the last sample
    logic [2:0] code;    // row, column and write strobes

    // no reset here: it must follow the pin through reset as well
    always_ff @(posedge sys_clk) mclk_q <= mem_out.memory_clock_out;
    // helpers for the properties
    assign tick = mem_out.memory_clock_out ^ mclk_q;
    assign code = {mem_out.ras_n, mem_out.cas_n, mem_out.we_n};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence tick_gap_s; !tick [*2] ##1 tick; endsequence
    sequence cs_slot_s; !mem_out.cs_n [*6] ##1 mem_out.cs_n; endsequence

    reset_state_a: assert property (disable iff (1'b0)
        !rst_n |=> mem_out.cs_n && !ctl_ready && !mem_out.dq_oe)
        else $error("outputs not idle after reset");
    tick_rate_a: assert property (tick |=> tick_gap_s)
        else $error("memory clock half period not three cycles");
    tick_only_a: assert property (!tick |-> $stable(mem_out))
        else $error("memory pins changed between ticks");
    cs_width_a: assert property ($fell(mem_out.cs_n) |-> cs_slot_s)
        else $error("select low not exactly one memory cycle");
    cs_gap_a: assert property ($rose(mem_out.cs_n) |-> mem_out.cs_n [*6])
        else $error("select asserted in adjacent memory cycles");
    addr_hold_a: assert property ($fell(mem_out.cs_n) |=>
        ($stable(mem_out.addr) && $stable(mem_out.bank)) [*5])
        else $error("address moved while selected");
    single_nop_a: assert property (
        $fell(mem_out.cs_n) && !dual_cycle_cmd_timing |->
        $past(code, 3) == 3'h7 ##6 code == 3'h7)
        else $error("single-cycle code not one memory cycle");
    dual_hold_a: assert property (
        $fell(mem_out.cs_n) && dual_cycle_cmd_timing |->
        code == $past(code, 3) && code != 3'h7)
        else $error("dual-cycle code not set before select");
    launch_edge_a: assert property (
        $fell(mem_out.cs_n) && !dual_cycle_cmd_timing |->
        mem_out.memory_clock_out == LAUNCH_HI)
        else $error("command launched on the wrong edge");
    dqs_edge_a: assert property (
        mem_out.dqs_oe |-> mem_out.dqs_out == mem_out.memory_clock_out)
        else $error("strobe not aligned with memory clock");
    dq_strobe_a: assert property (mem_out.dq_oe |-> mem_out.dqs_oe)
        else $error("data driven without strobe");
endmodule : dpwc_top_sva

bind dpwc_top dpwc_top_sva #(.AC_PHASE(AC_PHASE)) u_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .half_rate_sys_clk(half_rate_sys_clk),
    .ctl_valid(ctl_valid), .ctl_cmd(ctl_cmd), .ctl_ready(ctl_ready),
    .dual_cycle_cmd_timing(dual_cycle_cmd_timing), .mem_out(mem_out));

`default_nettype wire

// ==== dpwc_mem_model.sv ====
// Purpose: memory-side receiver that decodes commands and write beats
// Assumes: pins change only when the memory clock toggles
// Notes:   receive only, so it can neither stall nor drive the bus
`default_nettype none

module dpwc_mem_model
    import dpwc_pkg::*;
(
    input  wire logic          sys_clk,   // system clock
    input  wire logic          rst_n,     // reset, active low
    input  wire dpwc_mem_out_t mem_out,   // pins from the block
    output logic               cmd_stb,   // one selected command seen
    output dpwc_mem_out_t      cmd_snap,  // pins at the select edge
    output logic [2:0]         pre_code,  // code a half-cycle before
    output logic [2:0]         post_code, // code two half-cycles after
    output logic               post_cs_n, // select two half-cycles after
    output logic               word_stb,  // four beats gathered
    output logic [WORD_W-1:0]  word_data, // first beat in the low byte
    output logic [MASK_W-1:0]  word_mask  // mask bits in beat order
);
    timeunit 1ns;
    timeprecision 100ps;

    dpwc_mem_out_t hist [4];  // pins at the last four half-cycles
    logic          mclk_q;    // memory clock at the last sample
    int            beat;      // beats gathered of the current word

    // decode on every memory clock edge, as a device would
    always @(posedge sys_clk) begin
        cmd_stb <= 1'b0;
        word_stb <= 1'b0;
        mclk_q <= mem_out.memory_clock_out;
        if (!rst_n) begin
            beat = 0;
        end else if (mem_out.memory_clock_out !== mclk_q) begin
            hist[3] = hist[2];
            hist[2] = hist[1];
            hist[1] = hist[0];
            hist[0] = mem_out;
            // a masked slot never decodes: only a select edge counts
            if (hist[2].cs_n === 1'b0 && hist[3].cs_n === 1'b1) begin
                cmd_stb <= 1'b1;
                cmd_snap <= hist[2];
                pre_code <= {hist[3].ras_n, hist[3].cas_n, hist[3].we_n};
                post_code <= {hist[0].ras_n, hist[0].cas_n, hist[0].we_n};
                post_cs_n <= hist[0].cs_n;
            end
            // beats on both edges, the first on a rising edge
            if (mem_out.dq_oe === 1'b1 &&
                (beat > 0 || mem_out.memory_clock_out === 1'b1)) begin
                word_data[beat*8 +: 8] <= mem_out.dq_out;
                word_mask[beat] <= mem_out.write_byte_mask;
                beat = beat + 1;
                if (beat == 4) begin
                    word_stb <= 1'b1;
                    beat = 0;
                end
            end
        end
    end
endmodule : dpwc_mem_model

`default_nettype wire

// ==== ddr_phy_write_and_cmd_path_test.sv ====
// Purpose: self-checking bench for dpwc_top with a memory-side receiver
// Assumes: controller clock 64 ns, free running, unrelated to sys_clk
// Notes:   intake is slower than the drain, so the buffer never fills
`default_nettype none

module ddr_phy_write_and_cmd_path_test
    import dpwc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic          sys_clk, rst_n, half_rate_sys_clk, ctl_valid;
    logic          dual_cycle_cmd_timing, ctl_ready;
    dpwc_cmd_t     ctl_cmd, e, w;
    dpwc_mem_out_t mem_out, cmd_snap;
    logic          cmd_stb, post_cs_n, word_stb;
    logic [2:0]    pre_code, post_code;
    logic [WORD_W-1:0] word_data;
    logic [MASK_W-1:0] word_mask;
    int            errors, tests_run;
    dpwc_cmd_t     exp_cmd [$];
    dpwc_cmd_t     exp_wr [$];
    logic [2:0]    codes [6] = '{3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};

    dpwc_top #(.AC_PHASE(DPWC_PH_0)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n),
        .half_rate_sys_clk(half_rate_sys_clk), .ctl_valid(ctl_valid),
        .ctl_cmd(ctl_cmd), .dual_cycle_cmd_timing(dual_cycle_cmd_timing),
        .ctl_ready(ctl_ready), .mem_out(mem_out));
    dpwc_mem_model u_mem (
        .sys_clk(sys_clk), .rst_n(rst_n), .mem_out(mem_out),
        .cmd_stb(cmd_stb), .cmd_snap(cmd_snap), .pre_code(pre_code),
        .post_code(post_code), .post_cs_n(post_cs_n), .word_stb(word_stb),
        .word_data(word_data), .word_mask(word_mask));

    // clocks: phase offset keeps the two unrelated
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        half_rate_sys_clk = 1'b0;
        #7.3;
        forever #32 half_rate_sys_clk = ~half_rate_sys_clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("compares %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    // compare every decoded command and word with the queued model
    always @(posedge sys_clk) begin
        if (cmd_stb === 1'b1) begin
            if (exp_cmd.size() == 0) begin
                check(64'h1, 64'h0);
            end else begin
                e = exp_cmd.pop_front();
                check(64'(cmd_snap.addr), 64'(e.addr));
                check(64'(cmd_snap.bank), 64'(e.bank));
                check(64'({cmd_snap.ras_n, cmd_snap.cas_n, cmd_snap.we_n}),
                      64'({e.ras_n, e.cas_n, e.we_n}));
                check(64'({cmd_snap.cke, cmd_snap.odt}),
                      64'({e.cke, e.odt}));
                check(64'(pre_code), dual_cycle_cmd_timing ?
                      64'({e.ras_n, e.cas_n, e.we_n}) : 64'h7);
                if (!dual_cycle_cmd_timing) check(64'(post_code), 64'h7);
                check(64'(post_cs_n), 64'h1);
            end
        end
        if (word_stb === 1'b1) begin
            check(64'(exp_wr.size() != 0), 64'h1);
            w = (exp_wr.size() > 0) ? exp_wr.pop_front() : '0;
            check(64'(word_data), 64'(w.wdata));
            check(64'(word_mask), 64'(w.wmask));
        end
    end

    // one word per controller cycle, back to back, one per command
    task automatic run_test(input logic dual, input int n);
        dpwc_cmd_t c;
        // inputs move one step after the edge, mid-run reset included
        #1;
        rst_n = 1'b0;
        dual_cycle_cmd_timing = dual;
        repeat (16) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (20) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            c = '0;
            {c.ras_n, c.cas_n, c.we_n} = codes[i % 6];
            c.cs = (i % 5 != 3);
            c.write = c.cs && codes[i % 6] == 3'h4;
            c.cke = 1'b1;
            c.odt = 1'($urandom);
            c.bank = BANK_W'($urandom);
            c.addr = ADDR_W'($urandom);
            c.wdata = WORD_W'($urandom);
            c.wmask = MASK_W'($urandom);
            @(negedge half_rate_sys_clk);
            @(posedge sys_clk);
            #1;
            check(64'(ctl_ready), 64'h1);
            ctl_valid = 1'b1;
            ctl_cmd = c;
            if (c.cs) exp_cmd.push_back(c);
            if (c.write) exp_wr.push_back(c);
        end
        @(negedge half_rate_sys_clk);
        @(posedge sys_clk);
        #1 ctl_valid = 1'b0;
        repeat (200) @(posedge sys_clk);
        check(64'(exp_cmd.size()), 64'h0);
        check(64'(exp_wr.size()), 64'h0);
        $display("test dual=%0d done, compares so far %0d", dual, tests_run);
    endtask : run_test

    // main sequence: single-cycle timing, then dual-cycle after a reset
    initial begin
        errors = 0;
        tests_run = 0;
        rst_n = 1'b0;
        ctl_valid = 1'b0;
        ctl_cmd = '0;
        dual_cycle_cmd_timing = 1'b0;
        void'($urandom(32'h0402));
        run_test(1'b0, 18);
        run_test(1'b1, 18);
        tally_and_finish();
    end

    // watchdog well beyond the expected run time
    initial begin
        #50000;
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule : ddr_phy_write_and_cmd_path_test

`default_nettype wire
